// >>> hdl/core_bus_end.sv
// Core end: bus cycles, bus release to an external master, halt and
// deep stop with interrupt wake-up.
// Assumes the master shares clk; interrupt pins are asynchronous.
`timescale 1ns/1ps
module core_bus_end #(
	parameter int EXC_LEN = bus_release_pkg::EXC_CYCLES
) (
	input wire logic clk,
	input wire logic rstn,
	shared_bus_if.core bus,
	input wire logic cycle_req,
	input wire logic cycle_fetch,
	input wire logic cycle_write,
	input wire logic cycle_wait,
	input wire logic [bus_release_pkg::ADDR_W-1:0] cycle_addr,
	input wire logic [bus_release_pkg::DATA_W-1:0] cycle_wdata,
	output logic cycle_done,
	output logic [bus_release_pkg::DATA_W-1:0] cycle_rdata,
	input wire logic halt_cmd,
	input wire logic deep_stop_instruction,
	input wire logic nmi_n,
	input wire logic level1_irq_n,
	input wire logic level2_irq_n,
	input wire logic level3_irq_n,
	output logic interrupt_ack_n,
	output logic [2:0] exc_level,
	output logic osc_enable,
	output logic halted,
	output logic released
);

	// ----------------------------------------------------------------
	// Elaboration check
	// ----------------------------------------------------------------
	if (EXC_LEN < 1 || EXC_LEN > 255) begin : g_bad_len
		$error("EXC_LEN must lie in 1..255");
	end

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		bus_release_pkg::core_state_t st;
		logic [bus_release_pkg::ADDR_W-1:0] addr;
		logic [bus_release_pkg::DATA_W-1:0] wdata;
		logic [bus_release_pkg::DATA_W-1:0] rdata;
		logic write;
		logic req_seen;
		logic grant_n;
		logic interrupt_ack_n_n;
		logic [7:0] exc_cnt;
		logic [2:0] level;
		logic [2:0] take;
		logic done;
		logic back_to_halt;
		logic osc_on;
		logic [3:0] irq_s1;
		logic [3:0] irq_s2;
		logic nmi_prev;
		logic nmi_pend;
	} core_t;

	core_t s_r;
	core_t s_nxt;

	// Highest pending interrupt level, none when all are quiet
	function automatic logic [2:0] pending_level(input logic nmi, input logic [2:0] lv_n);
		if (nmi) begin
			return bus_release_pkg::LVL_NMI;
		end else if (!lv_n[2]) begin
			return bus_release_pkg::LVL_THREE;
		end else if (!lv_n[1]) begin
			return bus_release_pkg::LVL_TWO;
		end else if (!lv_n[0]) begin
			return bus_release_pkg::LVL_ONE;
		end
		return bus_release_pkg::LVL_NONE;
	endfunction

	logic [2:0] pend;
	logic nmi_fall;

	// Interrupt pins after the synchroniser's second stage
	assign nmi_fall = s_r.nmi_prev & ~s_r.irq_s2[3];
	assign pend = pending_level(s_r.nmi_pend | nmi_fall, s_r.irq_s2[2:0]);

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		s_nxt.irq_s1 = {nmi_n, level3_irq_n, level2_irq_n, level1_irq_n};
		s_nxt.irq_s2 = s_r.irq_s1;
		s_nxt.nmi_prev = s_r.irq_s2[3];
		if (nmi_fall) begin
			s_nxt.nmi_pend = 1'b1;
		end
		unique case (s_r.st)
			bus_release_pkg::CORE_IDLE: begin
				if (!bus.bus_request_n) begin
					s_nxt.grant_n = 1'b0;
					s_nxt.back_to_halt = 1'b0;
					s_nxt.st = bus_release_pkg::RELEASE_STATE_ONE;
				end else if (cycle_req && cycle_fetch && pend != bus_release_pkg::LVL_NONE) begin
					s_nxt.interrupt_ack_n_n = 1'b0;
					s_nxt.st = bus_release_pkg::EXCEPTION;
				end else if (cycle_req) begin
					s_nxt.addr = cycle_addr;
					s_nxt.wdata = cycle_wdata;
					s_nxt.write = cycle_write;
					s_nxt.st = bus_release_pkg::BUS_STATE_ONE;
				end else if (halt_cmd) begin
					s_nxt.st = bus_release_pkg::STOPPED_STATE_ONE;
				end else if (deep_stop_instruction) begin
					s_nxt.osc_on = 1'b0;
					s_nxt.st = bus_release_pkg::DEEP_STOP;
				end
			end
			bus_release_pkg::BUS_STATE_ONE: begin
				s_nxt.req_seen = 1'b0;
				s_nxt.st = bus_release_pkg::BUS_STATE_TWO;
			end
			bus_release_pkg::BUS_STATE_TWO: begin
				if (cycle_wait) begin
					s_nxt.st = bus_release_pkg::WAIT_STATE_ONE;
				end else begin
					s_nxt.req_seen = ~bus.bus_request_n;
					s_nxt.st = bus_release_pkg::BUS_STATE_THREE;
				end
			end
			bus_release_pkg::WAIT_STATE_ONE: begin
				s_nxt.req_seen = ~bus.bus_request_n;
				s_nxt.st = bus_release_pkg::BUS_STATE_THREE;
			end
			bus_release_pkg::BUS_STATE_THREE: begin
				s_nxt.st = bus_release_pkg::BUS_STATE_FOUR;
			end
			bus_release_pkg::BUS_STATE_FOUR: begin
				s_nxt.done = 1'b1;
				if (!s_r.write) begin
					s_nxt.rdata = bus.data;
				end
				// Low at both samples: hand over after this cycle
				if (s_r.req_seen && !bus.bus_request_n) begin
					s_nxt.grant_n = 1'b0;
					s_nxt.back_to_halt = 1'b0;
					s_nxt.st = bus_release_pkg::RELEASE_STATE_ONE;
				end else begin
					s_nxt.st = bus_release_pkg::CORE_IDLE;
				end
			end
			bus_release_pkg::RELEASE_STATE_ONE: begin
				s_nxt.st = bus_release_pkg::RELEASE_STATE_TWO;
			end
			bus_release_pkg::RELEASE_STATE_TWO: begin
				if (bus.bus_request_n) begin
					s_nxt.grant_n = 1'b1;
					s_nxt.st = s_r.back_to_halt ? bus_release_pkg::STOPPED_STATE_ONE
						: bus_release_pkg::CORE_IDLE;
				end else begin
					s_nxt.st = bus_release_pkg::RELEASE_STATE_ONE;
				end
			end
			bus_release_pkg::STOPPED_STATE_ONE: begin
				s_nxt.st = bus_release_pkg::STOPPED_STATE_TWO;
			end
			bus_release_pkg::STOPPED_STATE_TWO: begin
				if (pend != bus_release_pkg::LVL_NONE) begin
					s_nxt.interrupt_ack_n_n = 1'b0;
					s_nxt.st = bus_release_pkg::EXCEPTION;
				end else if (!bus.bus_request_n) begin
					s_nxt.grant_n = 1'b0;
					s_nxt.back_to_halt = 1'b1;
					s_nxt.st = bus_release_pkg::RELEASE_STATE_ONE;
				end else begin
					s_nxt.st = bus_release_pkg::STOPPED_STATE_ONE;
				end
			end
			bus_release_pkg::DEEP_STOP: begin
				// First clock let through samples the waking interrupt
				if (pend != bus_release_pkg::LVL_NONE) begin
					s_nxt.osc_on = 1'b1;
					s_nxt.interrupt_ack_n_n = 1'b0;
					s_nxt.st = bus_release_pkg::EXCEPTION;
				end
			end
			bus_release_pkg::EXCEPTION: begin
				// Request is not looked at while acknowledge is low
				if (s_r.exc_cnt == 8'(EXC_LEN - 1)) begin
					s_nxt.exc_cnt = '0;
					s_nxt.interrupt_ack_n_n = 1'b1;
					s_nxt.level = s_r.take;
					if (s_r.take == bus_release_pkg::LVL_NMI) begin
						s_nxt.nmi_pend = 1'b0;
					end
					s_nxt.st = bus_release_pkg::CORE_IDLE;
				end else begin
					s_nxt.exc_cnt = s_r.exc_cnt + 8'h01;
				end
			end
			default: begin
				s_nxt.st = bus_release_pkg::CORE_IDLE;
			end
		endcase
		// Keep the level taken; level pins may be let go during the acknowledge
		if (s_r.interrupt_ack_n_n && !s_nxt.interrupt_ack_n_n) begin
			s_nxt.take = pend;
		end
		// A new edge in the clearing cycle keeps the flag
		if (nmi_fall) begin
			s_nxt.nmi_pend = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rstn) begin
			s_r <= '{st: bus_release_pkg::CORE_IDLE, grant_n: 1'b1, interrupt_ack_n_n: 1'b1,
				osc_on: 1'b1, irq_s1: 4'hF, irq_s2: 4'hF, nmi_prev: 1'b1,
				default: '0};
		end else begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Bus drive, only while the grant is high
	// ----------------------------------------------------------------
	logic active;

	assign active = s_r.st == bus_release_pkg::BUS_STATE_TWO
		|| s_r.st == bus_release_pkg::WAIT_STATE_ONE
		|| s_r.st == bus_release_pkg::BUS_STATE_THREE
		|| s_r.st == bus_release_pkg::BUS_STATE_FOUR;
	assign bus.core_addr = s_r.addr;
	assign bus.core_addr_oe = s_r.grant_n;
	assign bus.core_data = s_r.wdata;
	assign bus.core_data_oe = s_r.grant_n & s_r.write & active;
	assign bus.core_strobe_oe = s_r.grant_n;
	assign bus.core_rd_n = ~(active & ~s_r.write);
	assign bus.core_wr_n = ~(active & s_r.write);
	assign bus.bus_grant_n = s_r.grant_n;

	// User-side outputs
	assign cycle_done = s_r.done;
	assign cycle_rdata = s_r.rdata;
	assign interrupt_ack_n = s_r.interrupt_ack_n_n;
	assign exc_level = s_r.level;
	assign osc_enable = s_r.osc_on;
	assign halted = s_r.st == bus_release_pkg::STOPPED_STATE_ONE
		|| s_r.st == bus_release_pkg::STOPPED_STATE_TWO;
	assign released = ~s_r.grant_n;

endmodule // core_bus_end

// >>> hdl/bus_release_pkg.sv
// Shared constants and types for the bus-release and standby pair.
// Assumes both ends run on one clock, clk, at 25 MHz.
//
// How it works
// - Released bus: address, data, strobes stop driving
// - Master asks by pulling request low
// - Request sampled at state two/wait and four
// - Low at both samples: grant low, enter release
// - Master drives bus only after grant low
// - Master holds request low while using bus
// - Release loops state one/two, sampling at two
// - Request high: grant rises, processing resumes
// - Grant possible at any bus-cycle boundary
// - No grant while interrupt acknowledge is low
// - Halted core samples request at stopped state two
// - Stop-CPU halts core only, oscillator keeps running
// - Halt left by nonmaskable or level interrupt
// - Registers hold their contents while halted
// - Halt loops stopped states, interrupts sampled at two
// - Deep stop halts core, peripherals and oscillator
// - Deep stop left by reset or interrupt
// - Peripheral gates clock until oscillator settles; not modelled, osc_enable rises as acknowledge goes low
// - First clock after deep stop samples interrupt
// - Exceptions sampled at fetch start; acknowledge low
package bus_release_pkg;

	// ----------------------------------------------------------------
	// Bus widths and acknowledge length
	// ----------------------------------------------------------------
	localparam int ADDR_W = 24;
	localparam int DATA_W = 8;
	localparam int EXC_CYCLES = 4; // Cycles the acknowledge stays low

	// ----------------------------------------------------------------
	// Interrupt levels reported with an accepted exception
	// ----------------------------------------------------------------
	localparam logic [2:0] LVL_NONE = 3'h0;
	localparam logic [2:0] LVL_ONE = 3'h1;
	localparam logic [2:0] LVL_TWO = 3'h2;
	localparam logic [2:0] LVL_THREE = 3'h3;
	localparam logic [2:0] LVL_NMI = 3'h4;

	// ----------------------------------------------------------------
	// Core sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		CORE_IDLE,
		BUS_STATE_ONE,
		BUS_STATE_TWO,
		WAIT_STATE_ONE,
		BUS_STATE_THREE,
		BUS_STATE_FOUR,
		RELEASE_STATE_ONE,
		RELEASE_STATE_TWO,
		STOPPED_STATE_ONE,
		STOPPED_STATE_TWO,
		DEEP_STOP,
		EXCEPTION
	} core_state_t;

	// Bus master states
	typedef enum logic [2:0] {
		MST_IDLE,
		MST_ASK,
		MST_SETUP,
		MST_STROBE,
		MST_FREE
	} mst_state_t;

endpackage

// >>> hdl/shared_bus_if.sv
// Shared system bus joining the core end and the external master.
// Assumes each side drives only under its own output enable.
`timescale 1ns/1ps
interface shared_bus_if;
	logic [bus_release_pkg::ADDR_W-1:0] core_addr;
	logic core_addr_oe;
	logic [bus_release_pkg::DATA_W-1:0] core_data;
	logic core_data_oe;
	logic core_rd_n;
	logic core_wr_n;
	logic core_strobe_oe;
	logic [bus_release_pkg::ADDR_W-1:0] mst_addr;
	logic mst_addr_oe;
	logic [bus_release_pkg::DATA_W-1:0] mst_data;
	logic mst_data_oe;
	logic mst_rd_n;
	logic mst_wr_n;
	logic mst_strobe_oe;
	logic bus_request_n;
	logic bus_grant_n;
	logic [bus_release_pkg::ADDR_W-1:0] addr;
	logic [bus_release_pkg::DATA_W-1:0] data;
	logic rd_n;
	logic wr_n;

	// Wire levels; an undriven line floats to ones as if pulled up
	assign addr = core_addr_oe ? core_addr : (mst_addr_oe ? mst_addr : '1);
	assign data = core_data_oe ? core_data : (mst_data_oe ? mst_data : '1);
	assign rd_n = core_strobe_oe ? core_rd_n : (mst_strobe_oe ? mst_rd_n : 1'b1);
	assign wr_n = core_strobe_oe ? core_wr_n : (mst_strobe_oe ? mst_wr_n : 1'b1);

	modport core (
		output core_addr, core_addr_oe, core_data, core_data_oe,
		output core_rd_n, core_wr_n, core_strobe_oe, bus_grant_n,
		input bus_request_n, data
	);
	modport master (
		output mst_addr, mst_addr_oe, mst_data, mst_data_oe,
		output mst_rd_n, mst_wr_n, mst_strobe_oe, bus_request_n,
		input bus_grant_n, data
	);
endinterface

// >>> hdl/bus_master_end.sv
// External master end: asks for the bus, does one transfer, hands back.
// Assumes the core end shares clk and answers on bus_grant_n.
`timescale 1ns/1ps
module bus_master_end (
	input wire logic clk,
	input wire logic rstn,
	shared_bus_if.master bus,
	input wire logic xfer_go,
	input wire logic xfer_write,
	input wire logic [bus_release_pkg::ADDR_W-1:0] xfer_addr,
	input wire logic [bus_release_pkg::DATA_W-1:0] xfer_wdata,
	output logic xfer_busy,
	output logic xfer_done,
	output logic [bus_release_pkg::DATA_W-1:0] xfer_rdata
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		bus_release_pkg::mst_state_t st;
		logic [bus_release_pkg::ADDR_W-1:0] addr;
		logic [bus_release_pkg::DATA_W-1:0] wdata;
		logic [bus_release_pkg::DATA_W-1:0] rdata;
		logic write;
		logic req_n;
		logic done;
	} mst_t;

	mst_t s_r;
	mst_t s_nxt;

	// Ask, wait for grant, transfer, release
	always_comb begin
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		unique case (s_r.st)
			bus_release_pkg::MST_IDLE: begin
				if (xfer_go) begin
					s_nxt.addr = xfer_addr;
					s_nxt.wdata = xfer_wdata;
					s_nxt.write = xfer_write;
					s_nxt.req_n = 1'b0;
					s_nxt.st = bus_release_pkg::MST_ASK;
				end
			end
			bus_release_pkg::MST_ASK: begin
				if (!bus.bus_grant_n) begin
					s_nxt.st = bus_release_pkg::MST_SETUP;
				end
			end
			bus_release_pkg::MST_SETUP: begin
				s_nxt.st = bus_release_pkg::MST_STROBE;
			end
			bus_release_pkg::MST_STROBE: begin
				if (!s_r.write) begin
					s_nxt.rdata = bus.data;
				end
				s_nxt.req_n = 1'b1;
				s_nxt.done = 1'b1;
				s_nxt.st = bus_release_pkg::MST_FREE;
			end
			bus_release_pkg::MST_FREE: begin
				// Wait until the core has taken the bus back
				if (bus.bus_grant_n) begin
					s_nxt.st = bus_release_pkg::MST_IDLE;
				end
			end
			default: begin
				s_nxt.st = bus_release_pkg::MST_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge clk) begin
		if (!rstn) begin
			s_r <= '{st: bus_release_pkg::MST_IDLE, req_n: 1'b1, default: '0};
		end else begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Bus drive, only in setup and strobe
	// ----------------------------------------------------------------
	logic own;

	assign own = s_r.st == bus_release_pkg::MST_SETUP || s_r.st == bus_release_pkg::MST_STROBE;
	assign bus.bus_request_n = s_r.req_n;
	assign bus.mst_addr = s_r.addr;
	assign bus.mst_addr_oe = own;
	assign bus.mst_data = s_r.wdata;
	assign bus.mst_data_oe = own & s_r.write;
	assign bus.mst_strobe_oe = own;
	assign bus.mst_rd_n = ~(s_r.st == bus_release_pkg::MST_STROBE && !s_r.write);
	assign bus.mst_wr_n = ~(s_r.st == bus_release_pkg::MST_STROBE && s_r.write);
	assign xfer_busy = s_r.st != bus_release_pkg::MST_IDLE;
	assign xfer_done = s_r.done;
	assign xfer_rdata = s_r.rdata;

endmodule // bus_master_end

// >>> tb/cpu_bus_release_and_standby_checker.sv
// Checker on the shared bus between the core end and the master end.
// Assumes one clock, clk, and a synchronous active-low reset, rstn.
`timescale 1ns/1ps
module cpu_bus_release_and_standby_checker (
	input wire logic clk,
	input wire logic rstn,
	input wire logic core_addr_oe,
	input wire logic core_data_oe,
	input wire logic core_strobe_oe,
	input wire logic mst_addr_oe,
	input wire logic mst_data_oe,
	input wire logic mst_strobe_oe,
	input wire logic bus_request_n,
	input wire logic bus_grant_n,
	input wire logic wr_n
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	// ----------------------------------------------------------------
	// Ownership of the bus
	// ----------------------------------------------------------------
	a_reset_grant_high: assert property ($rose(rstn) |-> bus_grant_n)
		else $error("grant low after reset");
	a_release_floats: assert property (!bus_grant_n |-> !core_addr_oe && !core_data_oe && !core_strobe_oe)
		else $error("core drives a released bus");
	a_grant_drives: assert property (bus_grant_n |-> core_addr_oe && core_strobe_oe)
		else $error("core floats bus while grant high");
	a_single_driver: assert property (!(core_addr_oe && mst_addr_oe) && !(core_strobe_oe && mst_strobe_oe))
		else $error("two drivers on the bus");

	// ----------------------------------------------------------------
	// Request and grant handshake
	// ----------------------------------------------------------------
	a_grant_needs_req: assert property ($fell(bus_grant_n) |-> $past(!bus_request_n))
		else $error("grant without request");
	a_grant_holds: assert property (!bus_grant_n && !bus_request_n |=> !bus_grant_n)
		else $error("grant dropped while request low");
	a_grant_rises: assert property (!bus_grant_n && bus_request_n |-> ##[1:3] bus_grant_n)
		else $error("grant not returned");
	a_master_in_grant: assert property ((mst_addr_oe || mst_data_oe || mst_strobe_oe) |-> !bus_grant_n && !bus_request_n)
		else $error("master drives outside grant");
	a_master_enters: assert property ($rose(mst_addr_oe) |-> $past(!bus_grant_n))
		else $error("master drove before seeing grant");

	// Main scenarios
	c_grant: cover property ($fell(bus_grant_n));
	c_return: cover property ($rose(bus_grant_n));
	c_master_write: cover property (mst_strobe_oe && !wr_n);
endmodule // cpu_bus_release_and_standby_checker

// >>> tb/cpu_bus_release_and_standby_tb_top.sv
// Testbench joining the core end and the master end over the shared bus.
// Assumes both ends and the interface under hdl/, one 25 MHz clock.
`timescale 1ns/1ps
module cpu_bus_release_and_standby_tb_top;
	localparam int EXC = 4;
	typedef struct {bit m; bit w; bit wt; logic [23:0] a; logic [7:0] d; int lat;} row_t;
	row_t rows[6] = '{'{0, 1, 0, 24'hFFFFFF, 8'hA5, 5}, '{0, 1, 1, 24'h000000, 8'h5A, 6},
		'{0, 0, 0, 24'h00F00F, 8'h00, 5}, '{0, 0, 1, 24'h800001, 8'h00, 6},
		'{1, 1, 0, 24'h7FFFFE, 8'hC3, 0}, '{1, 0, 0, 24'h010203, 8'h00, 0}};
	logic clk, rstn, cycle_req, cycle_fetch, cycle_write, cycle_wait, halt_cmd, deep_stop;
	logic [23:0] cycle_addr, xfer_addr, w_addr;
	logic [7:0] cycle_wdata, xfer_wdata, w_data, cycle_rdata, xfer_rdata;
	logic [3:0] irq_n;
	logic cycle_done, interrupt_ack_n, osc_enable, halted, released, g_q, rd_seen;
	logic xfer_go, xfer_write, xfer_busy, xfer_done;
	logic [2:0] exc_level;
	time t_done, t_grant;
	int fails, n_tests;

	shared_bus_if shared_bus_if_i ();
	core_bus_end #(.EXC_LEN(EXC)) core_bus_end_i (.clk(clk), .rstn(rstn), .bus(shared_bus_if_i),
		.cycle_req(cycle_req), .cycle_fetch(cycle_fetch), .cycle_write(cycle_write),
		.cycle_wait(cycle_wait), .cycle_addr(cycle_addr), .cycle_wdata(cycle_wdata),
		.cycle_done(cycle_done), .cycle_rdata(cycle_rdata), .halt_cmd(halt_cmd),
		.deep_stop_instruction(deep_stop), .nmi_n(irq_n[0]), .level3_irq_n(irq_n[1]),
		.level2_irq_n(irq_n[2]), .level1_irq_n(irq_n[3]), .interrupt_ack_n(interrupt_ack_n),
		.exc_level(exc_level), .osc_enable(osc_enable), .halted(halted), .released(released));
	bus_master_end bus_master_end_i (.clk(clk), .rstn(rstn), .bus(shared_bus_if_i),
		.xfer_go(xfer_go), .xfer_write(xfer_write), .xfer_addr(xfer_addr),
		.xfer_wdata(xfer_wdata), .xfer_busy(xfer_busy), .xfer_done(xfer_done),
		.xfer_rdata(xfer_rdata));
	cpu_bus_release_and_standby_checker cpu_bus_release_and_standby_checker_i (.clk(clk),
		.rstn(rstn), .core_addr_oe(shared_bus_if_i.core_addr_oe),
		.core_data_oe(shared_bus_if_i.core_data_oe), .core_strobe_oe(shared_bus_if_i.core_strobe_oe),
		.mst_addr_oe(shared_bus_if_i.mst_addr_oe), .mst_data_oe(shared_bus_if_i.mst_data_oe),
		.mst_strobe_oe(shared_bus_if_i.mst_strobe_oe), .bus_request_n(shared_bus_if_i.bus_request_n),
		.bus_grant_n(shared_bus_if_i.bus_grant_n), .wr_n(shared_bus_if_i.wr_n));

	// ----------------------------------------------------------------
	// Clock, watchdog and bus monitor
	// ----------------------------------------------------------------
	always #20 clk = ~clk;
	initial begin
		#400000;
		fails++;
		stop_test();
	end
	// Records the last write, read strobe, done time and grant time
	always @(posedge clk) begin
		if (shared_bus_if_i.wr_n === 1'b0) begin
			w_addr <= shared_bus_if_i.addr;
			w_data <= shared_bus_if_i.data;
		end
		if (shared_bus_if_i.rd_n === 1'b0) rd_seen <= 1'b1;
		if (cycle_done === 1'b1) t_done <= $time;
		if (shared_bus_if_i.bus_grant_n === 1'b0 && g_q === 1'b1) t_grant <= $time;
		g_q <= shared_bus_if_i.bus_grant_n;
	end

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic stop_test();
		if (fails == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Counts edges from the take edge until a done pulse, bounded
	task automatic wait_done(input bit m, output int n);
		for (n = 1; n < 40; n++) begin
			@(posedge clk);
			#1;
			if ((m ? xfer_done : cycle_done) === 1'b1) break;
		end
		check(n < 40, 1);
	endtask
	task automatic cyc(input bit w, input bit wt, input logic [23:0] a, input logic [7:0] d,
		input int lat);
		int n;
		@(negedge clk);
		while (released !== 1'b0) @(negedge clk);
		cycle_req = 1;
		cycle_write = w;
		cycle_wait = wt;
		cycle_addr = a;
		cycle_wdata = d;
		wait_done(0, n);
		@(negedge clk);
		cycle_req = 0;
		if (lat > 0) check(n, lat);
	endtask
	task automatic mx(input bit w, input logic [23:0] a, input logic [7:0] d);
		int n;
		@(negedge clk);
		while (xfer_busy !== 1'b0) @(negedge clk);
		xfer_go = 1;
		xfer_write = w;
		xfer_addr = a;
		xfer_wdata = d;
		@(negedge clk);
		xfer_go = 0;
		wait_done(1, n);
	endtask
	// Waits for the acknowledge, measures it, optionally asks for the bus meanwhile
	task automatic wait_ack(input logic [2:0] lvl, input bit go);
		int n;
		for (n = 0; n < 40 && interrupt_ack_n !== 1'b0; n++) @(negedge clk);
		check(osc_enable, 1);
		irq_n = 4'hF;
		for (n = 0; n < 20 && interrupt_ack_n === 1'b0; n++) begin
			check(shared_bus_if_i.bus_grant_n, 1);
			xfer_go = go && n == 0;
			@(negedge clk);
		end
		xfer_go = 0;
		check(n, EXC);
		check(exc_level, lvl);
		if (go) wait_done(1, n);
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		int n;
		logic [2:0] lvls[4] = '{bus_release_pkg::LVL_NMI, bus_release_pkg::LVL_THREE,
			bus_release_pkg::LVL_TWO, bus_release_pkg::LVL_ONE};
		{clk, rstn, cycle_req, cycle_fetch, cycle_write, cycle_wait, halt_cmd, deep_stop} = 0;
		{xfer_go, xfer_write, rd_seen, g_q} = 0;
		{cycle_addr, cycle_wdata, xfer_addr, xfer_wdata} = 0;
		irq_n = 4'hF;
		repeat (12) @(negedge clk);
		rstn = 1;
		check({shared_bus_if_i.bus_grant_n, interrupt_ack_n, osc_enable, xfer_busy}, 4'hE);
		foreach (rows[i]) begin
			rd_seen = 0;
			if (rows[i].m) mx(rows[i].w, rows[i].a, rows[i].d);
			else cyc(rows[i].w, rows[i].wt, rows[i].a, rows[i].d, rows[i].lat);
			if (rows[i].w) check({w_addr, w_data}, {rows[i].a, rows[i].d});
			else check({rows[i].m ? xfer_rdata : cycle_rdata, rd_seen}, 9'h1FF);
		end
		// Master asks while the core runs a cycle: the cycle ends first
		fork
			cyc(1, 0, 24'h123456, 8'h69, 5);
			mx(0, 24'h00FFFF, 8'h00);
		join
		check(w_data, 8'h69);
		check(t_grant >= t_done, 1);
		// Each interrupt source at a fetch, with a bus request refused meanwhile
		for (int k = 0; k < 4; k++) begin
			irq_n[k] = 0;
			repeat (5) @(negedge clk);
			cycle_fetch = 1;
			cycle_req = 1;
			wait_ack(lvls[k], 1);
			wait_done(0, n);
			@(negedge clk);
			{cycle_req, cycle_fetch} = 0;
		end
		// Halt, bus use from halt, wake by a level interrupt
		halt_cmd = 1;
		@(negedge clk);
		halt_cmd = 0;
		repeat (3) @(negedge clk);
		check({halted, osc_enable}, 2'h3);
		mx(1, 24'h00A5A5, 8'h3C);
		check(w_data, 8'h3C);
		repeat (3) @(negedge clk);
		check({halted, cycle_rdata}, 9'h1FF);
		irq_n[3] = 0;
		wait_ack(bus_release_pkg::LVL_ONE, 0);
		check(halted, 0);
		// Deep stop, wake by the nonmaskable edge
		deep_stop = 1;
		@(negedge clk);
		deep_stop = 0;
		repeat (3) @(negedge clk);
		check(osc_enable, 0);
		irq_n[0] = 0;
		wait_ack(bus_release_pkg::LVL_NMI, 0);
		// Reset in the middle of a release
		xfer_go = 1;
		@(negedge clk);
		xfer_go = 0;
		for (n = 0; n < 10 && shared_bus_if_i.bus_grant_n !== 1'b0; n++) @(negedge clk);
		rstn = 0;
		repeat (2) @(negedge clk);
		rstn = 1;
		check({shared_bus_if_i.bus_grant_n, interrupt_ack_n, xfer_busy}, 3'h6);
		cyc(1, 0, 24'h0F0F0F, 8'h96, 5);
		check(w_data, 8'h96);
		stop_test();
	end
endmodule // cpu_bus_release_and_standby_tb_top
